/* File: fps_phase_sequencer.v */
// command, execution and result phase sequencer with 16-byte data fifo
`timescale 1ns/1ps
`include "fps_map.vh"
module fps_phase_sequencer #(
  parameter DEPTH = `FPS_FIFO_DEPTH,
  parameter CW = 5
) (
  input wire mclk, // system clock
  input wire reset_n, // hardware reset pin
  input wire [`FPS_ADDR_W-1:0] addr, // register address
  input wire [7:0] wdata, // write data
  input wire wr_stb, // write strobe
  input wire rd_stb, // read strobe
  output reg [7:0] rdata, // read data, cycle after read
  input wire dma_ack_n, // dma acknowledge pin
  input wire count_done_input, // terminal count pin, mode polarity
  input wire io_rd_n, // dma read strobe pin
  input wire io_wr_n, // dma write strobe pin
  input wire [7:0] disk_rdata, // byte from disk side
  input wire disk_rvalid, // disk delivers a byte
  input wire disk_rd_take, // disk side takes a byte
  input wire sector_last, // last byte of a sector at disk side
  input wire disk_error, // overrun or underrun on disk side
  input wire density_hi, // wanted high density
  output reg [7:0] disk_wdata, // byte to disk side
  output reg floppy_irq_out, // interrupt pin level
  output reg floppy_irq_oe, // interrupt pin enable
  output reg dma_request_out, // dma request pin level
  output reg dma_request_oe, // dma request pin enable
  output reg density_select_out, // density pin, mode polarity
  output reg core_reset // core held in reset
);
  // ==========================================================
  // reset release and pin sync
  reg [1:0] rst_sync_reg;
  wire rst_n = rst_sync_reg[1];
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n)
      rst_sync_reg <= 2'h0;
    else
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  reg [3:0] pin_s1_reg, pin_s2_reg;
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_reg <= 4'hF;
      pin_s2_reg <= 4'hF;
    end else begin
      pin_s1_reg <= {dma_ack_n, count_done_input, io_rd_n, io_wr_n};
      pin_s2_reg <= pin_s1_reg;
    end
  end
  reg ack_d_reg;
  wire ack = ~pin_s2_reg[3];
  wire rd_act = ~pin_s2_reg[1];
  wire wr_act = ~pin_s2_reg[0];
  wire ack_edge = ack & ~ack_d_reg;
  // ==========================================================
  // registers
  reg [7:0] dor_reg, cfg3_reg, setup_reg, xfer_reg, status_reg;
  reg dsr_rst_reg;
  wire mode_b = ~cfg3_reg[`FPS_CFG3_PLAT_B] & cfg3_reg[`FPS_CFG3_ENC_B];
  wire mode_a = cfg3_reg[`FPS_CFG3_PLAT_B];
  // count done is active low only in mode b
  wire tc = mode_b ? ~pin_s2_reg[2] : pin_s2_reg[2];
  wire soft_rst = dor_reg[`FPS_DOR_RST_B] | dsr_rst_reg;
  wire dma_mode = setup_reg[`FPS_SET_DMA_B];
  wire [4:0] thr = {1'b0, setup_reg[`FPS_SET_THR_HI:`FPS_SET_THR_LO]} +
    5'h01;
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dor_reg <= 8'h04;
      dsr_rst_reg <= 1'b0;
      cfg3_reg <= 8'h40;
    end else begin
      dsr_rst_reg <= 1'b0;
      if (wr_stb && addr == `FPS_A_DOR)
        dor_reg <= wdata;
      if (wr_stb && addr == `FPS_A_DSR)
        dsr_rst_reg <= wdata[`FPS_DSR_RST_B];
      if (wr_stb && addr == `FPS_A_CFG3)
        cfg3_reg <= wdata;
    end
  end
  // ==========================================================
  // phase machine and fifo
  reg [2:0] state_reg;
  // phase encodings
  localparam [2:0] PH_IDLE = `FPS_ST_IDLE;
  localparam [2:0] PH_CMD = `FPS_ST_CMD;
  localparam [2:0] PH_EXEC = `FPS_ST_EXEC;
  localparam [2:0] PH_RES = `FPS_ST_RES;
  localparam [2:0] PH_BAD = `FPS_ST_BAD;
  reg [3:0] cnt_reg;
  reg [7:0] op_reg, last_sec_reg, sec_reg;
  reg rqm_reg, dio_reg, irq_reg, drq_reg, busy_reg, rdir_reg;
  reg fifo_en_reg, abn_reg;
  reg [7:0] mem [0:DEPTH-1];
  reg [3:0] wp_reg, rp_reg;
  reg [CW-1:0] fill_reg;
  wire full = fill_reg == DEPTH[CW-1:0];
  wire empty = fill_reg == {CW{1'b0}};
  wire exec = state_reg == PH_EXEC;
  wire data_wr = wr_stb && addr == `FPS_A_DATA;
  wire data_rd = rd_stb && addr == `FPS_A_DATA;
  // dma ack with a read or write strobe selects the fifo, no address needed
  wire dma_rd = exec & dma_mode & ack_edge & rd_act;
  wire dma_wr = exec & dma_mode & ack_edge & wr_act;
  // verify: ack alone, byte mode read
  wire verify = exec & dma_mode & ack_edge & ~rd_act & ~wr_act &
    rdir_reg & ~fifo_en_reg;
  wire host_pop = exec & rdir_reg & ~empty &
    ((data_rd & ~dma_mode) | dma_rd | verify);
  wire host_push = exec & ~rdir_reg & ~full &
    ((data_wr & ~dma_mode) | dma_wr);
  wire disk_push = exec & rdir_reg & disk_rvalid & ~full;
  wire disk_pop = exec & ~rdir_reg & disk_rd_take & ~empty;
  wire push = host_push | disk_push;
  wire pop = host_pop | disk_pop;
  // byte mode behaves as threshold of one entry
  wire [4:0] lvl = fifo_en_reg ? thr : 5'h01;
  wire rd_hit = fill_reg >= (DEPTH[CW-1:0] - lvl) ||
    (disk_push & sector_last);
  wire wr_room = (DEPTH[CW-1:0] - fill_reg) >= lvl;
  wire tc_hit = tc & ack;
  wire last_done = disk_push & sector_last & sec_reg == last_sec_reg;
  wire implicit_end = disk_error | last_done;
  always @(posedge mclk) begin
    if (push)
      mem[wp_reg] <= disk_push ? disk_rdata : wdata;
  end
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= `FPS_ST_IDLE;
      cnt_reg <= 4'h0;
      op_reg <= 8'h00;
      last_sec_reg <= 8'h00;
      sec_reg <= 8'h00;
      rqm_reg <= 1'b0;
      dio_reg <= 1'b0;
      irq_reg <= 1'b0;
      drq_reg <= 1'b0;
      busy_reg <= 1'b0;
      rdir_reg <= 1'b0;
      fifo_en_reg <= 1'b0;
      abn_reg <= 1'b0;
      setup_reg <= 8'h00;
      xfer_reg <= 8'h00;
      status_reg <= 8'h00;
      wp_reg <= 4'h0;
      rp_reg <= 4'h0;
      fill_reg <= {CW{1'b0}};
      ack_d_reg <= 1'b0;
      disk_wdata <= 8'h00;
    end else if (soft_rst) begin
      state_reg <= `FPS_ST_IDLE;
      rqm_reg <= 1'b0;
      dio_reg <= 1'b0;
      irq_reg <= 1'b0;
      drq_reg <= 1'b0;
      busy_reg <= 1'b0;
      fifo_en_reg <= 1'b0;
      status_reg <= 8'h00;
      wp_reg <= 4'h0;
      rp_reg <= 4'h0;
      fill_reg <= {CW{1'b0}};
      ack_d_reg <= ack;
    end else begin
      ack_d_reg <= ack;
      if (push)
        wp_reg <= wp_reg + 4'h1;
      if (pop)
        rp_reg <= rp_reg + 4'h1;
      if (push & ~pop)
        fill_reg <= fill_reg + {{(CW-1){1'b0}}, 1'b1};
      else if (pop & ~push)
        fill_reg <= fill_reg - {{(CW-1){1'b0}}, 1'b1};
      if (disk_pop)
        disk_wdata <= mem[rp_reg];
      if (wr_stb && addr == `FPS_A_SETUP)
        setup_reg <= wdata;
      if (wr_stb && addr == `FPS_A_XFER)
        xfer_reg <= wdata;
      case (state_reg)
        PH_IDLE: begin
          rqm_reg <= 1'b1;
          dio_reg <= 1'b0;
          busy_reg <= 1'b0;
          fifo_en_reg <= 1'b0;
          if (data_wr && rqm_reg) begin
            rqm_reg <= 1'b0;
            busy_reg <= 1'b1;
            op_reg <= wdata;
            cnt_reg <= 4'h0;
            if (wdata == `FPS_OP_READ || wdata == `FPS_OP_WRITE ||
                wdata == `FPS_OP_VALID)
              state_reg <= `FPS_ST_CMD;
            else
              state_reg <= `FPS_ST_BAD;
          end
        end
        PH_CMD: begin
          if (!rqm_reg && cnt_reg != `FPS_PARAM_N) begin
            rqm_reg <= 1'b1;
          end else if (data_wr && rqm_reg) begin
            rqm_reg <= 1'b0;
            cnt_reg <= cnt_reg + 4'h1;
            if (cnt_reg == 4'h0)
              last_sec_reg <= wdata;
          end else if (cnt_reg == `FPS_PARAM_N) begin
            // last parameter taken, rqm stays clear except on a non-dma write
            fifo_en_reg <= setup_reg[`FPS_SET_FEN_B];
            rdir_reg <= op_reg == `FPS_OP_READ;
            sec_reg <= 8'h00;
            abn_reg <= 1'b0;
            if (op_reg == `FPS_OP_VALID) begin
              status_reg <= 8'h00;
              state_reg <= `FPS_ST_RES;
              cnt_reg <= 4'h0;
              irq_reg <= 1'b1;
            end else begin
              state_reg <= `FPS_ST_EXEC;
              // write: request on entry
              irq_reg <= op_reg == `FPS_OP_WRITE && !dma_mode;
              rqm_reg <= op_reg == `FPS_OP_WRITE && !dma_mode;
              drq_reg <= op_reg == `FPS_OP_WRITE && dma_mode;
            end
          end
        end
        PH_EXEC: begin
          dio_reg <= rdir_reg;
          if (disk_push && sector_last)
            sec_reg <= sec_reg + 8'h01;
          if (rdir_reg) begin
            if (!dma_mode) begin
              if (rd_hit) begin
                irq_reg <= 1'b1;
                rqm_reg <= 1'b1;
              end else if (empty || (fill_reg == 5'h01 && host_pop)) begin
                irq_reg <= 1'b0;
                rqm_reg <= 1'b0;
              end
            end else if (rd_hit)
              drq_reg <= 1'b1;
            else if (empty || (fill_reg == 5'h01 && (ack | rd_act)))
              drq_reg <= 1'b0;
          end else begin
            if (!dma_mode) begin
              if (full || (host_push && fill_reg == 5'h0F)) begin
                irq_reg <= 1'b0;
                rqm_reg <= 1'b0;
              end else if (wr_room && !abn_reg) begin
                irq_reg <= 1'b1;
                rqm_reg <= 1'b1;
              end
              if (!tc && !ack && abn_reg)
                irq_reg <= 1'b0;
            end else if (full || tc_hit || abn_reg)
              drq_reg <= 1'b0;
            else if (wr_room)
              drq_reg <= 1'b1;
          end
          if (tc_hit || implicit_end) begin
            abn_reg <= 1'b1;
            status_reg <= implicit_end && !tc_hit ? `FPS_ST_ABN :
              8'h00;
          end
          // finish the sector as though count done came: drain fifo
          if (abn_reg && empty) begin
            state_reg <= `FPS_ST_RES;
            cnt_reg <= 4'h0;
            drq_reg <= 1'b0;
            irq_reg <= 1'b1;
            rqm_reg <= 1'b1;
            dio_reg <= 1'b1;
          end
        end
        PH_BAD: begin
          status_reg <= `FPS_ST_BADCMD;
          irq_reg <= 1'b1;
          state_reg <= `FPS_ST_RES;
          cnt_reg <= 4'h0;
        end
        PH_RES: begin
          rqm_reg <= 1'b1;
          dio_reg <= 1'b1;
          if (data_rd) begin
            irq_reg <= 1'b0;
            cnt_reg <= cnt_reg + 4'h1;
            if (cnt_reg == `FPS_RES_N - 4'h1) begin
              state_reg <= `FPS_ST_IDLE;
              dio_reg <= 1'b0;
              busy_reg <= 1'b0;
            end
          end
        end
        default: state_reg <= `FPS_ST_IDLE;
      endcase
    end
  end
  // ==========================================================
  // read port and pins
  wire [7:0] msr = {rqm_reg, dio_reg, exec & ~dma_mode, busy_reg, 4'h0};
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 8'h00;
      floppy_irq_out <= 1'b0;
      floppy_irq_oe <= 1'b0;
      dma_request_out <= 1'b0;
      dma_request_oe <= 1'b0;
      density_select_out <= 1'b0;
      core_reset <= 1'b1;
    end else begin
      rdata <= 8'h00;
      if (rd_stb) begin
        case (addr)
          `FPS_A_STATUS: rdata <= msr;
          `FPS_A_DOR: rdata <= dor_reg;
          `FPS_A_CFG3: rdata <= cfg3_reg;
          `FPS_A_SETUP: rdata <= setup_reg;
          `FPS_A_XFER: rdata <= xfer_reg;
          `FPS_A_RESULT: rdata <= status_reg;
          `FPS_A_DATA: rdata <= state_reg == `FPS_ST_RES ? status_reg :
            mem[rp_reg];
          default: rdata <= 8'h00;
        endcase
      end
      floppy_irq_out <= irq_reg;
      dma_request_out <= drq_reg;
      // mode b ignores dma enable, else it gates the pins
      floppy_irq_oe <= mode_b | dor_reg[`FPS_DOR_DMA_B];
      dma_request_oe <= mode_b | dor_reg[`FPS_DOR_DMA_B];
      density_select_out <= mode_a ? density_hi : ~density_hi;
      core_reset <= soft_rst;
    end
  end
endmodule // fps_phase_sequencer

/* File: fps_map.vh */
// register offsets, field positions and constants of the phase sequencer
`ifndef FPS_MAP_VH
`define FPS_MAP_VH
`define FPS_ADDR_W 3
`define FPS_A_STATUS 3'h0
`define FPS_A_DOR 3'h1
`define FPS_A_DSR 3'h2
`define FPS_A_DATA 3'h3
`define FPS_A_CFG3 3'h4
`define FPS_A_SETUP 3'h5
`define FPS_A_XFER 3'h6
`define FPS_A_RESULT 3'h7
`define FPS_DOR_RST_B 2
`define FPS_DOR_DMA_B 3
`define FPS_DSR_RST_B 7
`define FPS_CFG3_PLAT_B 6
`define FPS_CFG3_ENC_B 5
`define FPS_MSR_RQM_B 7
`define FPS_MSR_DIO_B 6
`define FPS_MSR_NDMA_B 5
`define FPS_MSR_CB_B 4
`define FPS_SET_DMA_B 0
`define FPS_SET_FEN_B 1
`define FPS_SET_THR_LO 4
`define FPS_SET_THR_HI 7
`define FPS_ST_IDLE 3'h0
`define FPS_ST_CMD 3'h1
`define FPS_ST_EXEC 3'h2
`define FPS_ST_RES 3'h3
`define FPS_ST_BAD 3'h4
`define FPS_OP_VALID 8'h01
`define FPS_OP_READ 8'h02
`define FPS_OP_WRITE 8'h03
`define FPS_PARAM_N 4'h2
`define FPS_RES_N 4'h2
`define FPS_ST_ABN 8'h40
`define FPS_ST_BADCMD 8'h80
`define FPS_FIFO_DEPTH 16
`endif

/* File: fps_seq_checker.sv */
// assertion checker watching the phase sequencer ports
`timescale 1ns/1ps
`include "fps_map.vh"
module fps_seq_checker (
  input wire mclk, // clock
  input wire reset_n, // pin reset
  input wire [`FPS_ADDR_W-1:0] addr, // address
  input wire [7:0] wdata, // write data
  input wire wr_stb, // write strobe
  input wire rd_stb, // read strobe
  input wire [7:0] rdata, // read data
  input wire density_hi, // density wanted
  input wire floppy_irq_out, // irq level
  input wire floppy_irq_oe, // irq enable
  input wire dma_request_out, // request level
  input wire dma_request_oe, // request enable
  input wire density_select_out, // density pin
  input wire core_reset // core in reset
);
  reg [7:0] dor_sh; // shadow of output register
  reg [7:0] cfg_sh; // shadow of config 3
  reg [2:0] calm; // cycles since a mode change
  reg seen; // config 3 written once
  wire dor_wr = wr_stb && addr == `FPS_A_DOR;
  wire cfg_wr = wr_stb && addr == `FPS_A_CFG3;
  wire dsr_go = wr_stb && addr == `FPS_A_DSR && wdata[`FPS_DSR_RST_B];
  wire dor_rst = dor_sh[`FPS_DOR_RST_B];
  wire mode_a = cfg_sh[`FPS_CFG3_PLAT_B];
  wire mode_b = !mode_a && cfg_sh[`FPS_CFG3_ENC_B];
  wire oe_exp = mode_b || dor_sh[`FPS_DOR_DMA_B];
  // ==========
  // register shadows
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      dor_sh <= 8'h04;
      cfg_sh <= 8'h40;
      calm <= 3'h0;
      seen <= 1'b0;
    end else begin
      if (dor_wr) dor_sh <= wdata;
      if (cfg_wr) cfg_sh <= wdata;
      if (cfg_wr) seen <= 1'b1;
      if (dor_wr || cfg_wr || dsr_go || core_reset || $changed(density_hi))
        calm <= 3'h0;
      else if (calm != 3'h4 && seen) calm <= calm + 3'h1;
    end
  end
  // ==========
  // properties
  default clocking dclk @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  sequence s_rst_up;
    ##[1:4] core_reset;
  endsequence
  sequence s_rst_down;
    ##[1:100] !core_reset;
  endsequence
  chk_rdata_quiet: assert property (!$past(rd_stb) |-> rdata == 8'h00)
    else $error("read data without a read");
  chk_pin_reset: assert property ($rose(reset_n) |-> core_reset [*3])
    else $error("core left reset early");
  chk_dor_enter: assert property (
    dor_wr && wdata[`FPS_DOR_RST_B] |-> ##[1:3] core_reset)
    else $error("output register reset not taken");
  chk_dor_hold: assert property (
    dor_rst && $past(dor_rst, 3) |-> core_reset)
    else $error("core out of reset with reset bit set");
  chk_dsr_pulse: assert property (
    dsr_go && !dor_rst |-> s_rst_up ##0 s_rst_down)
    else $error("rate reset not a self-clearing pulse");
  chk_core_quiet: assert property (
    core_reset [*3] |-> !floppy_irq_out && !dma_request_out)
    else $error("requests active in reset");
  chk_oe_mode: assert property (
    calm == 3'h4 |-> floppy_irq_oe == oe_exp && dma_request_oe == oe_exp)
    else $error("pin enable wrong for mode");
  chk_density_pol: assert property (calm == 3'h4 |->
    density_select_out == (mode_a ? density_hi : !density_hi))
    else $error("density polarity wrong for mode");
endmodule // fps_seq_checker
bind fps_phase_sequencer fps_seq_checker fps_seq_checker_inst (
  .mclk(mclk), .reset_n(reset_n), .addr(addr), .wdata(wdata),
  .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .density_hi(density_hi),
  .floppy_irq_out(floppy_irq_out), .floppy_irq_oe(floppy_irq_oe),
  .dma_request_out(dma_request_out), .dma_request_oe(dma_request_oe),
  .density_select_out(density_select_out), .core_reset(core_reset)
);

/* File: fps_dma_model.sv */
// dma controller model answering the request pin
`timescale 1ns/1ps
module fps_dma_model (
  input wire mclk, // clock
  input wire req, // request seen on the pin
  input wire [7:0] n, // bytes to move
  output reg ack_n, // acknowledge
  output reg iow_n, // write strobe
  output reg ior_n, // read strobe, idle here
  output reg tc, // count done, active high
  output reg [7:0] done // bytes moved
);
  initial begin
    ack_n = 1'b1;
    iow_n = 1'b1;
    ior_n = 1'b1;
    tc = 1'b0;
    done = 8'h00;
    forever begin
      @(posedge mclk);
      if (req && done < n) begin
        ack_n <= 1'b0;
        iow_n <= 1'b0;
        tc <= (done == n - 8'h01);
        repeat (4) @(posedge mclk);
        ack_n <= 1'b1;
        iow_n <= 1'b1;
        tc <= 1'b0;
        done <= done + 8'h01;
        repeat (6) @(posedge mclk);
      end
    end
  end
endmodule // fps_dma_model

/* File: fps_phase_sequencer_tb_top.sv */
// self-checking bench for the phase sequencer
`timescale 1ns/1ps
`include "fps_map.vh"
module fps_phase_sequencer_tb_top;
  logic mclk, reset_n = 1'b0, wr_stb = 1'b0, rd_stb = 1'b0;
  logic density_hi = 1'b0, drain = 1'b0, disk_rvalid = 1'b0;
  logic disk_error = 1'b0, disk_rd_take = 1'b0, sector_last = 1'b0;
  logic dma_ack_n, count_done_input, io_rd_n, io_wr_n;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00, disk_rdata = 8'h00, n_dma = 8'h00;
  logic [7:0] rdata, disk_wdata, st, dma_done;
  logic floppy_irq_out, floppy_irq_oe, dma_request_out, dma_request_oe;
  logic density_select_out, core_reset;
  logic [18:0] rows [0:6];
  int err_total = 0, n_compared = 0, i;
  fps_phase_sequencer fps_phase_sequencer_inst (
    .mclk(mclk), .reset_n(reset_n), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .dma_ack_n(dma_ack_n), .count_done_input(count_done_input),
    .io_rd_n(io_rd_n), .io_wr_n(io_wr_n), .disk_rdata(disk_rdata),
    .disk_rvalid(disk_rvalid), .disk_rd_take(disk_rd_take),
    .sector_last(sector_last), .disk_error(disk_error),
    .density_hi(density_hi),
    .disk_wdata(disk_wdata), .floppy_irq_out(floppy_irq_out),
    .floppy_irq_oe(floppy_irq_oe), .dma_request_out(dma_request_out),
    .dma_request_oe(dma_request_oe),
    .density_select_out(density_select_out), .core_reset(core_reset)
  );
  fps_dma_model fps_dma_model_inst (
    .mclk(mclk), .req(dma_request_out & dma_request_oe), .n(n_dma),
    .ack_n(dma_ack_n), .iow_n(io_wr_n), .ior_n(io_rd_n),
    .tc(count_done_input), .done(dma_done)
  );
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // disk side takes a byte every other cycle
  always @(posedge mclk) disk_rd_take <= drain && !disk_rd_take;
  // ==========
  // tasks
  task automatic conclude;
    if (err_total == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge mclk);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge mclk);
    rd_stb <= 1'b0;
    #1 d = rdata;
  endtask
  function automatic logic sig(input int s);
    case (s)
      0: sig = floppy_irq_out;
      1: sig = dma_request_out;
      2: sig = core_reset;
      default: sig = (dma_done == n_dma);
    endcase
  endfunction
  task automatic hit(input int s, input logic v);
    int k;
    #1;
    for (k = 0; k < 3000 && sig(s) !== v; k++) #4;
    chk({7'h0, sig(s)}, {7'h0, v});
    if (sig(s) !== v) conclude();
  endtask
  task automatic rqm_wait;
    int k;
    st = 8'h00;
    repeat (2) @(posedge mclk);
    for (k = 0; k < 200 && st[7:6] !== 2'b10; k++) rd(`FPS_A_STATUS, st);
    if (st[7:6] !== 2'b10) begin
      chk(st, 8'h80);
      conclude();
    end
  endtask
  task automatic cmd(input logic [7:0] op);
    rqm_wait();
    wr(`FPS_A_DATA, op);
    rqm_wait();
    wr(`FPS_A_DATA, 8'h01);
    rqm_wait();
    wr(`FPS_A_DATA, 8'h00);
  endtask
  task automatic done_chk;
    rqm_wait();
    chk(st & 8'hD0, 8'h80);
  endtask
  task automatic push(input logic [7:0] d, input logic l);
    @(posedge mclk);
    disk_rdata <= d;
    disk_rvalid <= 1'b1;
    sector_last <= l;
    @(posedge mclk);
    disk_rvalid <= 1'b0;
    sector_last <= 1'b0;
    repeat (3) @(posedge mclk);
    #1;
  endtask
  // ==========
  // main sequence
  initial begin
    rows = '{{8'h40, 8'h08, 3'b111}, {8'h40, 8'h00, 3'b000},
      {8'h60, 8'h00, 3'b101}, {8'h20, 8'h00, 3'b110},
      {8'h20, 8'h08, 3'b011}, {8'h00, 8'h08, 3'b110},
      {8'h00, 8'h00, 3'b001}};
    repeat (16) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (4) @(posedge mclk);
    #1 chk({7'h0, core_reset}, 8'h01);
    rd(`FPS_A_DOR, st);
    chk(st, 8'h04);
    wr(`FPS_A_CFG3, 8'h00);
    wr(`FPS_A_DSR, 8'h80);
    repeat (40) @(posedge mclk);
    #1 chk({7'h0, core_reset}, 8'h01);
    wr(`FPS_A_DOR, 8'h00);
    hit(2, 1'b0);
    wr(`FPS_A_DSR, 8'h80);
    hit(2, 1'b1);
    hit(2, 1'b0);
    for (i = 0; i < 7; i++) begin
      wr(`FPS_A_CFG3, rows[i][18:11]);
      wr(`FPS_A_DOR, rows[i][10:3]);
      density_hi <= rows[i][2];
      repeat (6) @(posedge mclk);
      #1 chk({7'h0, floppy_irq_oe}, {7'h0, rows[i][1]});
      chk({7'h0, dma_request_oe}, {7'h0, rows[i][1]});
      chk({7'h0, density_select_out}, {7'h0, rows[i][0]});
    end
    wr(`FPS_A_DOR, 8'h08);
    rqm_wait();
    wr(`FPS_A_DATA, 8'hFF);
    hit(0, 1'b1);
    rd(`FPS_A_STATUS, st);
    chk(st & 8'hC0, 8'hC0);
    rd(`FPS_A_DATA, st);
    chk(st, `FPS_ST_BADCMD);
    rd(`FPS_A_DATA, st);
    done_chk();
    wr(`FPS_A_SETUP, 8'h33);
    n_dma <= 8'h14;
    drain <= 1'b1;
    cmd(`FPS_OP_WRITE);
    rd(`FPS_A_STATUS, st);
    chk(st & 8'h80, 8'h00);
    hit(1, 1'b1);
    hit(3, 1'b1);
    hit(1, 1'b0);
    hit(0, 1'b1);
    rd(`FPS_A_DATA, st);
    chk(st & `FPS_ST_ABN, 8'h00);
    rd(`FPS_A_DATA, st);
    done_chk();
    drain <= 1'b0;
    wr(`FPS_A_SETUP, 8'h32);
    cmd(`FPS_OP_WRITE);
    hit(0, 1'b1);
    for (i = 0; i < 16; i++) wr(`FPS_A_DATA, 8'h20 + i[7:0]);
    hit(0, 1'b0);
    drain <= 1'b1;
    hit(0, 1'b1);
    repeat (40) @(posedge mclk);
    disk_error <= 1'b1;
    @(posedge mclk);
    disk_error <= 1'b0;
    repeat (8) @(posedge mclk);
    rd(`FPS_A_STATUS, st);
    chk(st & 8'hC0, 8'hC0);
    rd(`FPS_A_DATA, st);
    chk(st & `FPS_ST_ABN, `FPS_ST_ABN);
    rd(`FPS_A_DATA, st);
    done_chk();
    chk(disk_wdata, 8'h2F);
    drain <= 1'b0;
    cmd(`FPS_OP_READ);
    for (i = 0; i < 12; i++) begin
      if (i == 11) chk({7'h0, floppy_irq_out}, 8'h00);
      push(8'h10 + i[7:0], 1'b0);
    end
    hit(0, 1'b1);
    for (i = 0; i < 12; i++) begin
      rd(`FPS_A_DATA, st);
      chk(st, 8'h10 + i[7:0]);
    end
    hit(0, 1'b0);
    @(posedge mclk);
    disk_error <= 1'b1;
    @(posedge mclk);
    disk_error <= 1'b0;
    hit(0, 1'b1);
    rd(`FPS_A_DATA, st);
    chk(st & `FPS_ST_ABN, `FPS_ST_ABN);
    rd(`FPS_A_DATA, st);
    done_chk();
    cmd(`FPS_OP_READ);
    push(8'h55, 1'b1);
    hit(0, 1'b1);
    rd(`FPS_A_DATA, st);
    chk(st, 8'h55);
    hit(0, 1'b0);
    push(8'h66, 1'b1);
    hit(0, 1'b1);
    rd(`FPS_A_DATA, st);
    chk(st, 8'h66);
    rd(`FPS_A_DATA, st);
    chk(st & `FPS_ST_ABN, `FPS_ST_ABN);
    rd(`FPS_A_DATA, st);
    done_chk();
    rqm_wait();
    wr(`FPS_A_DATA, `FPS_OP_READ);
    wr(`FPS_A_DOR, 8'h0C);
    hit(2, 1'b1);
    rd(`FPS_A_STATUS, st);
    chk(st, 8'h00);
    wr(`FPS_A_DOR, 8'h08);
    hit(2, 1'b0);
    done_chk();
    @(posedge mclk);
    reset_n <= 1'b0;
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (4) @(posedge mclk);
    #1 chk({7'h0, core_reset}, 8'h01);
    rd(`FPS_A_DOR, st);
    chk(st, 8'h04);
    conclude();
  end
endmodule // fps_phase_sequencer_tb_top
